//--- common/sfm_pkg.sv
package sfm_pkg;

  // ****************************************************************
  // Frame layout.
  // ****************************************************************
  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_EDGES = 5'h18;
  localparam logic [CNT_W-1:0] CMD_END = 5'h07;
  localparam logic [CNT_W-1:0] DATA_FIRST = 5'h08;
  localparam logic [CNT_W-1:0] DATA_LAST = 5'h0F;
  localparam logic [CNT_W-1:0] CRC_COVER = 5'h10;

  // ****************************************************************
  // Checksum and commands.
  // ****************************************************************
  localparam logic [7:0] CRC_POLY = 8'h2F;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'hA5;

  // ****************************************************************
  // Status register link_transfer_status.
  // ****************************************************************
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int BIT_READBACK = 7;
  localparam int BIT_SHORT = 6;
  localparam int BIT_LONG = 5;
  localparam int BIT_BAD_CMD = 4;
  localparam int BIT_CHECKSUM = 3;
  localparam int BIT_CLK_FALL = 2;
  localparam int BIT_CLK_RISE = 1;
  localparam int BIT_RESET_TERM = 0;

  // ****************************************************************
  // Frame tracker states.
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FRAME = 2'b01,
    ST_ABORT = 2'b10
  } sfm_state_t;

endpackage

//--- hdl/sfm_pin_sync.sv
`timescale 1ns/1ns
// ****************************************************************
// Two-stage synchroniser with edge detection after the second stage.
// ****************************************************************
module sfm_pin_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Asynchronous pins
  input wire logic [W-1:0] pin_i,
  // Synchronised level and edges
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta;
      logic stable;
      logic prev;
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          meta <= 1'b0;
          stable <= 1'b0;
          prev <= 1'b0;
        end else begin
          meta <= pin_i[g];
          stable <= meta;
          prev <= stable;
        end
      end
      assign level_o[g] = stable;
      assign rise_o[g] = stable & ~prev;
      assign fall_o[g] = ~stable & prev;
    end
  endgenerate

endmodule // sfm_pin_sync

//--- hdl/sfm_frame_monitor.sv
`timescale 1ns/1ns
module sfm_frame_monitor (
  // Clock and power-on reset
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // Serial link pins
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic SDI_I,
  input wire logic SDO_FB_I,
  output logic SDO_O,
  output logic SDO_OE_N_O,
  // Device core
  input wire logic DEV_RESET_I,
  input wire logic CMD_DEFINED_I,
  output logic [7:0] CMD_O,
  output logic [7:0] DATA_O,
  output logic FRAME_OK_O,
  output logic [7:0] STATUS_O
);

  // ****************************************************************
  // Pin synchronisation.
  // ****************************************************************
  logic [3:0] pin_lvl;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;

  sfm_pin_sync #(
    .W(4)
  ) u_sync (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .pin_i({SDO_FB_I, SDI_I, CS_N_I, SCLK_I}),
    .level_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  logic sclk_lvl;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic sdi_lvl;
  logic fb_lvl;

  assign sclk_lvl = pin_lvl[0];
  assign sclk_rise = pin_rise[0];
  assign sclk_fall = pin_fall[0];
  assign cs_fall = pin_fall[1];
  assign cs_rise = pin_rise[1];
  assign sdi_lvl = pin_lvl[2];
  assign fb_lvl = pin_lvl[3];

  // ****************************************************************
  // Frame state.
  // ****************************************************************
  sfm_pkg::sfm_state_t state;
  sfm_pkg::sfm_state_t next_state;
  logic [sfm_pkg::CNT_W-1:0] rise_cnt;
  logic [sfm_pkg::CNT_W-1:0] next_rise_cnt;
  logic [sfm_pkg::CNT_W-1:0] fall_cnt;
  logic [sfm_pkg::CNT_W-1:0] next_fall_cnt;
  logic [sfm_pkg::FRAME_BITS-1:0] shift;
  logic [sfm_pkg::FRAME_BITS-1:0] next_shift;
  logic [7:0] crc;
  logic [7:0] next_crc;
  logic [7:0] ferr;
  logic [7:0] next_ferr;
  logic [7:0] flags;
  logic [7:0] next_flags;
  logic [7:0] snap;
  logic [7:0] next_snap;
  logic [7:0] cmd;
  logic [7:0] next_cmd;
  logic [7:0] data;
  logic [7:0] next_data;
  logic sdo;
  logic next_sdo;
  logic ok;
  logic next_ok;

  // Per-frame checks evaluated when select rises.
  logic [7:0] end_err;
  logic len_ok;
  logic crc_ok;
  logic is_read;
  logic crc_fb;

  always_comb begin
    len_ok = (rise_cnt == sfm_pkg::FRAME_EDGES) &&
             (fall_cnt == sfm_pkg::FRAME_EDGES);
    crc_ok = (crc == shift[7:0]);
    is_read = (cmd == sfm_pkg::CMD_READ_STATUS);
    end_err = ferr;
    if (sclk_lvl) begin
      end_err[sfm_pkg::BIT_CLK_RISE] = 1'b1;
    end
    if ((rise_cnt < sfm_pkg::FRAME_EDGES) ||
        (fall_cnt < sfm_pkg::FRAME_EDGES)) begin
      end_err[sfm_pkg::BIT_SHORT] = 1'b1;
    end
    if ((rise_cnt > sfm_pkg::FRAME_EDGES) ||
        (fall_cnt > sfm_pkg::FRAME_EDGES)) begin
      end_err[sfm_pkg::BIT_LONG] = 1'b1;
    end
    if (len_ok && !crc_ok) begin
      end_err[sfm_pkg::BIT_CHECKSUM] = 1'b1;
    end
    if (len_ok && crc_ok && !is_read && !CMD_DEFINED_I) begin
      end_err[sfm_pkg::BIT_BAD_CMD] = 1'b1;
    end
  end

  always_comb begin
    next_state = state;
    next_rise_cnt = rise_cnt;
    next_fall_cnt = fall_cnt;
    next_shift = shift;
    next_crc = crc;
    next_ferr = ferr;
    next_flags = flags;
    next_snap = snap;
    next_cmd = cmd;
    next_data = data;
    next_sdo = sdo;
    next_ok = 1'b0;
    crc_fb = crc[7] ^ sdi_lvl;
    case (state)
      sfm_pkg::ST_IDLE: begin
        next_sdo = 1'b0;
        if (cs_fall) begin
          next_state = sfm_pkg::ST_FRAME;
          next_rise_cnt = '0;
          next_fall_cnt = '0;
          next_crc = sfm_pkg::CRC_INIT;
          next_ferr = sfm_pkg::STATUS_RESET;
          next_ferr[sfm_pkg::BIT_CLK_FALL] = sclk_lvl;
        end
      end
      sfm_pkg::ST_FRAME: begin
        if (DEV_RESET_I) begin
          next_ferr[sfm_pkg::BIT_RESET_TERM] = 1'b1;
          next_sdo = 1'b0;
          next_state = sfm_pkg::ST_ABORT;
        end else if (cs_rise) begin
          // Set wins over the read clear; a read frame's own errors stay.
          next_flags = (is_read && len_ok && crc_ok) ?
                       sfm_pkg::STATUS_RESET : flags;
          next_flags = next_flags | end_err;
          next_ok = (end_err == sfm_pkg::STATUS_RESET);
          next_data = shift[15:8];
          next_sdo = 1'b0;
          next_state = sfm_pkg::ST_IDLE;
        end else begin
          if (sclk_rise) begin
            next_shift = {shift[sfm_pkg::FRAME_BITS-2:0], sdi_lvl};
            if (rise_cnt != '1) begin
              next_rise_cnt = rise_cnt + 1'b1;
            end
            if (rise_cnt < sfm_pkg::CRC_COVER) begin
              next_crc = {crc[6:0], 1'b0} ^
                         (crc_fb ? sfm_pkg::CRC_POLY : 8'h00);
            end
            if (fb_lvl != sdo) begin
              next_ferr[sfm_pkg::BIT_READBACK] = 1'b1;
            end
            if (rise_cnt == sfm_pkg::CMD_END) begin
              next_cmd = {shift[6:0], sdi_lvl};
              next_snap = flags;
            end
          end
          if (sclk_fall) begin
            if (fall_cnt != '1) begin
              next_fall_cnt = fall_cnt + 1'b1;
            end
            if (is_read && (rise_cnt >= sfm_pkg::DATA_FIRST) &&
                (rise_cnt <= sfm_pkg::DATA_LAST)) begin
              next_sdo = snap[3'h7 - rise_cnt[2:0]];
            end else begin
              next_sdo = 1'b0;
            end
          end
        end
      end
      sfm_pkg::ST_ABORT: begin
        // The cut-off frame carries only its abort, clock and readback results.
        next_sdo = 1'b0;
        if (cs_rise) begin
          next_flags = flags | ferr;
          next_flags[sfm_pkg::BIT_CLK_RISE] = flags[sfm_pkg::BIT_CLK_RISE]
                                              | sclk_lvl;
          next_state = sfm_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = sfm_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State registers.
  // ****************************************************************
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state <= sfm_pkg::ST_IDLE;
      rise_cnt <= '0;
      fall_cnt <= '0;
      shift <= '0;
      crc <= sfm_pkg::CRC_INIT;
      ferr <= sfm_pkg::STATUS_RESET;
      flags <= sfm_pkg::STATUS_RESET;
      snap <= sfm_pkg::STATUS_RESET;
      cmd <= 8'h00;
      data <= 8'h00;
      sdo <= 1'b0;
      ok <= 1'b0;
    end else begin
      state <= next_state;
      rise_cnt <= next_rise_cnt;
      fall_cnt <= next_fall_cnt;
      shift <= next_shift;
      crc <= next_crc;
      ferr <= next_ferr;
      flags <= next_flags;
      snap <= next_snap;
      cmd <= next_cmd;
      data <= next_data;
      sdo <= next_sdo;
      ok <= next_ok;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign SDO_O = sdo;
  assign SDO_OE_N_O = (state != sfm_pkg::ST_FRAME);
  assign CMD_O = cmd;
  assign DATA_O = data;
  assign FRAME_OK_O = ok;
  assign STATUS_O = flags;

endmodule // sfm_frame_monitor

//--- bench/sfm_props.sv
`timescale 1ns/1ns
module sfm_props (
  // Clock
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // Watched
  input wire logic DEV_RESET_I,
  input wire logic SDO_OE_N_O,
  input wire logic [7:0] CMD_O,
  input wire logic [7:0] DATA_O,
  input wire logic FRAME_OK_O,
  input wire logic [7:0] STATUS_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!ARST_N_I);
  sequence s_abort;
    DEV_RESET_I && !SDO_OE_N_O;
  endsequence
  sequence s_clr;
    |($past(STATUS_O) & ~STATUS_O);
  endsequence
  property p_init; $rose(ARST_N_I) |-> STATUS_O == 8'h00; endproperty
  a_init: assert property (p_init)
    else $error("init");
  property p_idle; $changed(STATUS_O) |-> SDO_OE_N_O; endproperty
  a_idle: assert property (p_idle)
    else $error("idle");
  property p_clr; s_clr |-> CMD_O == sfm_pkg::CMD_READ_STATUS; endproperty
  a_clr: assert property (p_clr)
    else $error("clr");
  property p_ok; FRAME_OK_O |-> !(|(STATUS_O & ~$past(STATUS_O)));
  endproperty
  a_ok: assert property (p_ok)
    else $error("ok");
  property p_pulse; FRAME_OK_O |=> !FRAME_OK_O; endproperty
  a_pulse: assert property (p_pulse)
    else $error("pulse");
  property p_abort; s_abort |-> ##[0:4] SDO_OE_N_O; endproperty
  a_abort: assert property (p_abort)
    else $error("abort");
  property p_cmd; $changed(CMD_O) |-> !SDO_OE_N_O; endproperty
  a_cmd: assert property (p_cmd)
    else $error("cmd");
  property p_data; $changed(DATA_O) |-> SDO_OE_N_O; endproperty
  a_data: assert property (p_data)
    else $error("data");
endmodule // sfm_props
bind sfm_frame_monitor sfm_props u_sfm_props (.CLK_I(CLK_I),
  .ARST_N_I(ARST_N_I), .DEV_RESET_I(DEV_RESET_I),
  .SDO_OE_N_O(SDO_OE_N_O), .CMD_O(CMD_O), .DATA_O(DATA_O),
  .FRAME_OK_O(FRAME_OK_O), .STATUS_O(STATUS_O));

//--- bench/sfm_host.sv
`timescale 1ns/1ns
module sfm_host (
  // Clock
  input wire logic clk_i,
  // Link
  input wire logic sdo_i,
  input wire logic sdo_oe_n_i,
  input wire logic bad_fb_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  output logic sdo_fb_o
);
  logic [7:0] rx;
  // A released pin reads back as the inverse of its last level.
  assign sdo_fb_o = sdo_oe_n_i ? ~sdo_i : sdo_i ^ bad_fb_i;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
    rx = 8'h00;
  end
  task automatic frame(input int n, input logic [23:0] w,
                       input logic hs, input logic he);
    sclk_o = hs;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    repeat (4) @(negedge clk_i);
    for (int i = 0; i < n; i++) begin
      sclk_o = 1'b0;
      sdi_o = w[23 - (i % 24)];
      repeat (4) @(negedge clk_i);
      if (i > 7 && i < 16) rx = {rx[6:0], sdo_i};
      sclk_o = 1'b1;
      repeat (4) @(negedge clk_i);
    end
    sclk_o = he;
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    repeat (4) @(negedge clk_i);
    sclk_o = 1'b0;
    repeat (6) @(negedge clk_i);
  endtask
endmodule // sfm_host

//--- bench/tb_sfm_frame_monitor.sv
`timescale 1ns/1ns
module tb_sfm_frame_monitor;
  logic clk, arst_n, sclk, cs_n, sdi, sdo_fb, sdo, sdo_oe_n;
  logic dev_rst, def, bad, ok;
  logic [7:0] cmd, data, status;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int ok_count = 0;
  sfm_frame_monitor u_sfm_frame_monitor (.CLK_I(clk), .ARST_N_I(arst_n),
    .SCLK_I(sclk), .CS_N_I(cs_n), .SDI_I(sdi), .SDO_FB_I(sdo_fb),
    .SDO_O(sdo), .SDO_OE_N_O(sdo_oe_n), .DEV_RESET_I(dev_rst),
    .CMD_DEFINED_I(def), .CMD_O(cmd), .DATA_O(data), .FRAME_OK_O(ok),
    .STATUS_O(status));
  sfm_host u_sfm_host (.clk_i(clk), .sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n),
    .bad_fb_i(bad), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
    .sdo_fb_o(sdo_fb));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  // Counts clean-frame pulses away from the edge that launches them.
  always @(negedge clk) begin
    if (ok === 1'b1) begin
      ok_count <= ok_count + 1;
    end
  end
  function automatic logic [23:0] fr(input logic [7:0] c, d);
    logic [15:0] v;
    logic [7:0] r;
    v = {c, d};
    r = sfm_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      r = {r[6:0], 1'b0} ^ ((v[i] ^ r[7]) ? sfm_pkg::CRC_POLY : 8'h00);
    end
    return {v, r};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic err(input string nm, input logic [7:0] exp);
    int n;
    chk(status, exp);
    def = 1'b1;
    bad = 1'b0;
    n = ok_count;
    u_sfm_host.frame(24, fr(8'hA5, 8'h00), 1'b0, 1'b0);
    chk(u_sfm_host.rx, exp);
    chk(status, 8'h00);
    chk(cmd, sfm_pkg::CMD_READ_STATUS);
    chk(8'(ok_count - n), 8'h01);
    chk({7'h00, sdo_oe_n}, 8'h01);
    $display("test %s done", nm);
  endtask
  task automatic t_hold;
    int n;
    n = ok_count;
    u_sfm_host.frame(23, fr(8'h12, 8'h34), 1'b0, 1'b0);
    u_sfm_host.frame(24, fr(8'h12, 8'h56), 1'b0, 1'b0);
    chk(data, 8'h56);
    chk(8'(ok_count - n), 8'h01);
    err("hold", 8'h40);
  endtask
  task automatic t_long;
    u_sfm_host.frame(25, fr(8'h12, 8'h34), 1'b0, 1'b0);
    err("long", 8'h20);
  endtask
  task automatic t_cmd;
    def = 1'b0;
    u_sfm_host.frame(24, fr(8'h3C, 8'h34), 1'b0, 1'b0);
    chk(cmd, 8'h3C);
    err("cmd", 8'h10);
  endtask
  task automatic t_crc;
    u_sfm_host.frame(24, fr(8'h12, 8'h34) ^ 24'h000001, 1'b0, 1'b0);
    err("crc", 8'h08);
  endtask
  task automatic t_clk;
    u_sfm_host.frame(24, fr(8'h12, 8'h34), 1'b1, 1'b1);
    err("clk_both", 8'h06);
    u_sfm_host.frame(24, fr(8'h12, 8'h34), 1'b1, 1'b0);
    err("clk_fall", 8'h24);
    u_sfm_host.frame(24, fr(8'h12, 8'h34), 1'b0, 1'b1);
    err("clk_rise", 8'h42);
  endtask
  task automatic t_fb;
    bad = 1'b1;
    u_sfm_host.frame(24, fr(8'h12, 8'h34), 1'b0, 1'b0);
    // A read while the fault persists clears and re-sets the flag.
    u_sfm_host.frame(24, fr(8'hA5, 8'h00), 1'b0, 1'b0);
    chk(u_sfm_host.rx, 8'h80);
    chk(status, 8'h80);
    err("fb", 8'h80);
  endtask
  task automatic t_abort;
    fork
      u_sfm_host.frame(24, fr(8'h12, 8'h34), 1'b0, 1'b0);
      begin
        repeat (60) @(negedge clk);
        dev_rst = 1'b1;
        @(negedge clk);
        dev_rst = 1'b0;
      end
    join
    err("abort", 8'h01);
  endtask
  task automatic t_por;
    u_sfm_host.frame(23, fr(8'h12, 8'h34), 1'b0, 1'b0);
    chk(status, 8'h40);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(status, 8'h00);
    $display("test por done");
  endtask
  task automatic stop_test;
    $display("checks=%0d fails=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    arst_n = 1'b0;
    dev_rst = 1'b0;
    def = 1'b1;
    bad = 1'b0;
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(status, 8'h00);
    t_hold();
    t_long();
    t_cmd();
    t_crc();
    t_clk();
    t_fb();
    t_abort();
    t_por();
    stop_test();
  end
endmodule // tb_sfm_frame_monitor
